// ---- rtl/ebc_pkg.sv ----
// ebc_pkg: constants, carriers and state type of the bit error test control
// assumes a single 40 MHz clock shared with the framer bit strobes
package ebc_pkg;

    // register byte offsets
    localparam logic [31:0] OFS_CTL = 32'h0000_0000;
    localparam logic [31:0] OFS_DIR = 32'h0000_0004;
    localparam logic [31:0] OFS_ISTS = 32'h0000_0008;
    localparam logic [31:0] OFS_IMASK = 32'h0000_000c;

    // control and direction register fields
    localparam int BIT_TYPE = 7;
    localparam int BIT_INJ = 6;
    localparam int BIT_INV = 5;
    localparam int BIT_LOCK = 4;
    localparam int BIT_CHK = 3;
    localparam int BIT_GEN = 2;
    localparam int BIT_RXSKIP = 1;
    localparam int BIT_TXSKIP = 0;
    localparam int BIT_SWITCH = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'hef;

    // interrupt status bits
    localparam int IRQ_GAIN = 0;
    localparam int IRQ_LOSS = 1;

    // pattern structure
    localparam logic [19:0] GEN_SEED = 20'hfffff;
    localparam int P15_TAP_A = 14;
    localparam int P15_TAP_B = 13;
    localparam int QR_TAP_A = 19;
    localparam int QR_TAP_B = 16;
    localparam logic [3:0] QR_ZERO_MAX = 4'he;

    // checker thresholds in received bits
    localparam logic [5:0] LOCK_GOOD = 6'h28;
    localparam logic [5:0] LOCK_BAD = 6'h04;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic en;
        logic data;
    } ebc_bit_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic dir;
        logic [1:0] ists;
        logic [1:0] imask;
        logic [19:0] gen;
        logic [3:0] zrun;
        logic [19:0] hist;
        logic [5:0] good;
        logic [5:0] bad;
        logic lock;
        logic pend;
        logic inj_d;
        ebc_bit_t tx_o;
        ebc_bit_t rx_o;
        logic aw_got;
        logic [31:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_be;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ebc_state_t;

endpackage : ebc_pkg

// ---- rtl/ebc_bert_ctrl.sv ----
// ebc_bert_ctrl: bit error test generator, checker and framer skip controls
// assumes bit strobes and data come from framer logic on aclk
`timescale 1ns/1ps
`default_nettype none

// Contract
// - type bit picks prbs15 or quasi-random
// - direction switch held in separate register
// - switch off: generate toward line
// - switch on: generate toward receive backplane
// - rising inject flips exactly one bit
// - inject works only with generator enabled
// - injected error follows generator direction
// - switch off: invert line output, line input
// - switch on: invert backplane out, tx in
// - lock flag shows checker synchronisation
// - switch off: check line receive data
// - switch on: check transmit backplane data
// - generator enable starts generator per direction
// - receive skip bypasses receive framing
// - transmit skip bypasses transmit framing
module ebc_bert_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ebc_pkg::ebc_bit_t tx_bp_i,
    input wire ebc_pkg::ebc_bit_t rx_line_i,
    output ebc_pkg::ebc_bit_t tx_line_o,
    output ebc_pkg::ebc_bit_t rx_bp_o,
    output logic receive_framer_skip,
    output logic transmit_framer_skip,
    output logic irq
);

    ebc_pkg::ebc_state_t st_reg;
    ebc_pkg::ebc_state_t st_next;

    // address decode: {hit, index}
    function automatic logic [2:0] dec(input logic [31:0] a);
        case (a)
            ebc_pkg::OFS_CTL: dec = 3'h4;
            ebc_pkg::OFS_DIR: dec = 3'h5;
            ebc_pkg::OFS_ISTS: dec = 3'h6;
            ebc_pkg::OFS_IMASK: dec = 3'h7;
            default: dec = 3'h0;
        endcase
    endfunction : dec

    // feedback of the selected polynomial
    function automatic logic fb(input logic typ, input logic [19:0] s);
        if (typ) begin
            fb = s[ebc_pkg::QR_TAP_A] ^ s[ebc_pkg::QR_TAP_B];
        end else begin
            fb = s[ebc_pkg::P15_TAP_A] ^ s[ebc_pkg::P15_TAP_B];
        end
    endfunction : fb

    logic typ;
    logic inv;
    logic gen_on;
    logic chk_on;
    logic sw;
    logic gen_stb;
    logic gen_bit;
    logic chk_stb;
    logic chk_bit;
    logic exp_bit;
    logic wr_go;
    logic [2:0] wdec;
    logic [2:0] rdec;

    assign typ = st_reg.ctl[ebc_pkg::BIT_TYPE];
    assign inv = st_reg.ctl[ebc_pkg::BIT_INV];
    assign gen_on = st_reg.ctl[ebc_pkg::BIT_GEN];
    assign chk_on = st_reg.ctl[ebc_pkg::BIT_CHK];
    assign sw = st_reg.dir;
    // generator paced by the framer that owns the output
    assign gen_stb = sw ? rx_line_i.en : tx_bp_i.en;
    // checker input follows the switch
    assign chk_stb = sw ? tx_bp_i.en : rx_line_i.en;
    assign chk_bit = (sw ? tx_bp_i.data : rx_line_i.data) ^ inv;
    assign exp_bit = fb(typ, st_reg.hist);
    // quasi-random output forces a one after a long zero run
    assign gen_bit = (typ && st_reg.zrun >= ebc_pkg::QR_ZERO_MAX) ? 1'b1
                     : fb(typ, st_reg.gen);
    assign wr_go = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    assign wdec = dec(st_reg.aw_addr);
    assign rdec = dec(s_axi_araddr);

    always_comb begin
        logic gain;
        logic loss;
        logic obit;
        gain = 1'b0;
        loss = 1'b0;
        obit = 1'b0;
        st_next = st_reg;

        // inject edge is armed only while generating
        st_next.inj_d = st_reg.ctl[ebc_pkg::BIT_INJ];
        if (!gen_on) begin
            st_next.pend = 1'b0;
        end else if (st_reg.ctl[ebc_pkg::BIT_INJ] && !st_reg.inj_d) begin
            st_next.pend = 1'b1;
        end

        // generator
        obit = gen_bit ^ inv ^ st_reg.pend;
        if (gen_on && gen_stb) begin
            st_next.gen = {st_reg.gen[18:0], fb(typ, st_reg.gen)};
            st_next.zrun = (gen_bit == 1'b0) ? st_reg.zrun + 4'h1 : 4'h0;
            if (st_reg.pend) begin
                st_next.pend = 1'b0;
            end
        end

        // outputs: generated bits replace data on one path only
        st_next.tx_o.en = tx_bp_i.en;
        st_next.rx_o.en = rx_line_i.en;
        if (tx_bp_i.en) begin
            st_next.tx_o.data = (gen_on && !sw) ? obit : tx_bp_i.data;
        end
        if (rx_line_i.en) begin
            st_next.rx_o.data = (gen_on && sw) ? obit : rx_line_i.data;
        end

        // checker
        if (!chk_on) begin
            st_next.lock = 1'b0;
            st_next.good = 6'h00;
            st_next.bad = 6'h00;
        end else if (chk_stb) begin
            st_next.hist = {st_reg.hist[18:0], chk_bit};
            if (chk_bit == exp_bit) begin
                if (st_reg.good != ebc_pkg::LOCK_GOOD) begin
                    st_next.good = st_reg.good + 6'h01;
                end else begin
                    st_next.bad = 6'h00;
                    st_next.lock = 1'b1;
                end
            end else begin
                st_next.good = 6'h00;
                if (st_reg.bad != ebc_pkg::LOCK_BAD) begin
                    st_next.bad = st_reg.bad + 6'h01;
                end else begin
                    st_next.lock = 1'b0;
                end
            end
        end
        gain = st_next.lock && !st_reg.lock;
        loss = !st_next.lock && st_reg.lock;

        // write channel
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got = 1'b1;
            st_next.w_data = s_axi_wdata[7:0];
            st_next.w_be = s_axi_wstrb[0];
        end
        if (wr_go) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = wdec[2] ? ebc_pkg::RESP_OKAY
                            : ebc_pkg::RESP_SLVERR;
            if (wdec[2] && st_reg.w_be) begin
                case (wdec[1:0])
                    2'h0: st_next.ctl = st_reg.w_data & ebc_pkg::CTL_WMASK;
                    2'h1: st_next.dir = st_reg.w_data[ebc_pkg::BIT_SWITCH];
                    2'h2: st_next.ists = st_reg.ists & ~st_reg.w_data[1:0];
                    2'h3: st_next.imask = st_reg.w_data[1:0];
                    default: st_next.dir = st_reg.dir;
                endcase
            end
        end else if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // sticky events win over a clear in the same cycle
        if (gain) begin
            st_next.ists[ebc_pkg::IRQ_GAIN] = 1'b1;
        end
        if (loss) begin
            st_next.ists[ebc_pkg::IRQ_LOSS] = 1'b1;
        end

        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = rdec[2] ? ebc_pkg::RESP_OKAY
                            : ebc_pkg::RESP_SLVERR;
            st_next.rdata = 32'h0000_0000;
            case (rdec)
                3'h4: begin
                    st_next.rdata[7:0] = st_reg.ctl;
                    st_next.rdata[ebc_pkg::BIT_LOCK] = st_reg.lock;
                end
                3'h5: st_next.rdata[ebc_pkg::BIT_SWITCH] = st_reg.dir;
                3'h6: st_next.rdata[1:0] = st_reg.ists;
                3'h7: st_next.rdata[1:0] = st_reg.imask;
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.ctl <= ebc_pkg::CTL_RESET;
            st_reg.gen <= ebc_pkg::GEN_SEED;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign tx_line_o = st_reg.tx_o;
    assign rx_bp_o = st_reg.rx_o;
    assign receive_framer_skip = st_reg.ctl[ebc_pkg::BIT_RXSKIP];
    assign transmit_framer_skip = st_reg.ctl[ebc_pkg::BIT_TXSKIP];
    assign irq = |(st_reg.ists & st_reg.imask);

    // checks
    property p_prbs15_line;
        @(posedge aclk) disable iff (!aresetn)
        (gen_on && !sw && !typ && !inv && !st_reg.pend && tx_bp_i.en)
        |=> tx_line_o.data == $past(st_reg.gen[14] ^ st_reg.gen[13]);
    endproperty
    a_prbs15_line: assert property (p_prbs15_line)
        else $error("prbs15 bit wrong on line output");

    property p_pass_line;
        @(posedge aclk) disable iff (!aresetn)
        (tx_bp_i.en && (!gen_on || sw)) |=> tx_line_o.data == $past(tx_bp_i.data);
    endproperty
    a_pass_line: assert property (p_pass_line)
        else $error("line output not passed through");

    property p_gen_bp;
        @(posedge aclk) disable iff (!aresetn)
        (gen_on && sw && !inv && !st_reg.pend && rx_line_i.en)
        |=> rx_bp_o.data == $past(gen_bit);
    endproperty
    a_gen_bp: assert property (p_gen_bp)
        else $error("backplane generator bit wrong");

    property p_inject;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.pend && gen_on && !sw && tx_bp_i.en)
        |=> tx_line_o.data == !$past(gen_bit ^ inv) ##1 !st_reg.pend;
    endproperty
    a_inject: assert property (p_inject)
        else $error("injected bit not inverted once");

    property p_no_inject;
        @(posedge aclk) disable iff (!aresetn)
        !gen_on |=> !st_reg.pend;
    endproperty
    a_no_inject: assert property (p_no_inject)
        else $error("inject armed while generator off");

    property p_invert;
        @(posedge aclk) disable iff (!aresetn)
        (gen_on && !sw && inv && !st_reg.pend && tx_bp_i.en)
        |=> tx_line_o.data == !$past(gen_bit);
    endproperty
    a_invert: assert property (p_invert)
        else $error("line output not inverted");

    property p_chk_off;
        @(posedge aclk) disable iff (!aresetn)
        !chk_on |=> !st_reg.lock ##1 (s_axi_rvalid -> !s_axi_rdata[4]
                    || st_reg.lock);
    endproperty
    a_chk_off: assert property (p_chk_off)
        else $error("lock held with checker off");

    property p_lock_read;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == ebc_pkg::OFS_CTL)
        |=> s_axi_rdata[4] == $past(st_reg.lock);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock flag read wrong");

    property p_lock_gain;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.lock) |-> st_reg.ists[0] && chk_on;
    endproperty
    a_lock_gain: assert property (p_lock_gain)
        else $error("lock gain not recorded");

    property p_skip_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && wdec == 3'h4 && st_reg.w_be)
        |=> {receive_framer_skip, transmit_framer_skip}
            == $past(st_reg.w_data[1:0]);
    endproperty
    a_skip_write: assert property (p_skip_write)
        else $error("framer skip bits not written");

    property p_chk_line;
        @(posedge aclk) disable iff (!aresetn)
        (chk_on && !sw && rx_line_i.en)
        |=> st_reg.hist[0] == ($past(rx_line_i.data) ^ $past(inv));
    endproperty
    a_chk_line: assert property (p_chk_line)
        else $error("checker did not take line data");

    property p_chk_bp;
        @(posedge aclk) disable iff (!aresetn)
        (chk_on && sw && tx_bp_i.en)
        |=> st_reg.hist[0] == ($past(tx_bp_i.data) ^ $past(inv));
    endproperty
    a_chk_bp: assert property (p_chk_bp)
        else $error("checker did not take backplane data");

    property p_lock_loss;
        @(posedge aclk) disable iff (!aresetn)
        $fell(st_reg.lock) |-> st_reg.ists[ebc_pkg::IRQ_LOSS];
    endproperty
    a_lock_loss: assert property (p_lock_loss)
        else $error("lock loss not recorded");

    property p_lock_src;
        @(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.lock)
        |-> ($past(sw) ? $past(tx_bp_i.en) : $past(rx_line_i.en));
    endproperty
    a_lock_src: assert property (p_lock_src)
        else $error("lock from wrong checker input");

    property p_gen_hold;
        @(posedge aclk) disable iff (!aresetn)
        !(gen_on && gen_stb) |=> st_reg.gen == $past(st_reg.gen);
    endproperty
    a_gen_hold: assert property (p_gen_hold)
        else $error("generator moved while idle");

    c_lock: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(st_reg.lock));
    c_inject: cover property (@(posedge aclk) disable iff (!aresetn)
        st_reg.pend ##1 !st_reg.pend);
    c_sw_gen: cover property (@(posedge aclk) disable iff (!aresetn)
        gen_on && sw && rx_line_i.en);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq));
    c_qr_force: cover property (@(posedge aclk) disable iff (!aresetn)
        typ && gen_on && gen_stb && st_reg.zrun >= ebc_pkg::QR_ZERO_MAX);

endmodule : ebc_bert_ctrl

`default_nettype wire

// ---- bench/ebc_link_model.sv ----
// ebc_link_model: line and backplane serial ports around the test block
// assumes bit requests come from the bench on aclk
`timescale 1ns/1ps
`default_nettype none
module ebc_link_model (
    input wire logic aclk,
    input wire logic strobe,
    input wire logic sw,
    input wire logic loop,
    input wire logic data_in,
    input wire ebc_pkg::ebc_bit_t tx_line,
    input wire ebc_pkg::ebc_bit_t rx_bp,
    output ebc_pkg::ebc_bit_t tx_bp,
    output ebc_pkg::ebc_bit_t rx_line
);
    // idle side carries changing data, or the looped-back output when loop is set
    always_ff @(posedge aclk) begin
        tx_bp <= sw ? (loop ? rx_bp : {1'b0, ~data_in}) : {strobe, data_in};
        rx_line <= sw ? {strobe, data_in}
                      : (loop ? tx_line : {1'b0, ~data_in});
    end
endmodule : ebc_link_model
`default_nettype wire

// ---- bench/ebc_bert_ctrl_tb.sv ----
// ebc_bert_ctrl_tb: self-checking bench for the bit error test control
// assumes ebc_link_model stands on the serial side
`timescale 1ns/1ps
`default_nettype none
module ebc_bert_ctrl_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd_l;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rr_l;
    logic strobe = 1'b0, sw = 1'b0, loop = 1'b0, din = 1'b0;
    logic rxs, txs, irq, typ, inv, pend;
    logic [19:0] gs;
    logic [15:0] rnd = 16'hc2a3;
    logic [3:0] wstrb = 4'h1;
    logic gon = 1'b0;
    int zr = 0;
    ebc_pkg::ebc_bit_t tx_bp, rx_line, tx_line, rx_bp;
    int mismatches = 0, n_compared = 0, cyc = 0;

    always #12.5 aclk = ~aclk;

    ebc_bert_ctrl i_ebc_bert_ctrl (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tx_bp_i(tx_bp), .rx_line_i(rx_line), .tx_line_o(tx_line),
        .rx_bp_o(rx_bp), .receive_framer_skip(rxs),
        .transmit_framer_skip(txs), .irq(irq));

    ebc_link_model i_ebc_link_model (
        .aclk(aclk), .strobe(strobe), .sw(sw), .loop(loop), .data_in(din),
        .tx_line(tx_line), .rx_bp(rx_bp), .tx_bp(tx_bp), .rx_line(rx_line));

    function automatic logic nxt(input logic [19:0] s, input logic t);
        return t ? s[19] ^ s[16] : s[14] ^ s[13];
    endfunction : nxt

    // quasi-random output forces a one after a long zero run
    function automatic logic gbit(input logic [19:0] s, input logic t,
                                  input int z);
        return (t && z >= ebc_pkg::QR_ZERO_MAX) ? 1'b1 : nxt(s, t);
    endfunction : gbit

    function automatic logic [15:0] lfsr(input logic [15:0] r);
        return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    endfunction : lfsr

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic rst();
        aresetn <= 1'b0;
        sw <= 1'b0;
        loop <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        gs = 20'hfffff;
        typ = 1'b0;
        inv = 1'b0;
        pend = 1'b0;
        zr = 0;
    endtask : rst

    task automatic axw(input logic [31:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rr_l = bresp;
    endtask : axw

    task automatic axr(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd_l = rdata;
        rr_l = rresp;
    endtask : axr

    // one generated bit, random payload and gap
    task automatic send();
        logic e;
        logic g;
        rnd = lfsr(rnd);
        g = gbit(gs, typ, zr);
        e = gon ? g ^ inv ^ pend : rnd[0];
        if (gon) begin
            zr = g ? 0 : zr + 1;
            pend = 1'b0;
            gs = {gs[18:0], nxt(gs, typ)};
        end
        @(posedge aclk);
        strobe <= 1'b1;
        din <= rnd[0];
        @(posedge aclk);
        strobe <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        chk("gen_bit", {31'h0, sw ? rx_bp.data : tx_line.data}, {31'h0, e});
        repeat (rnd[2:1]) @(posedge aclk);
    endtask : send

    initial begin
        rst();
        axr(32'h0);
        chk("ctl_reset", rd_l, 32'h0);
        axr(32'h10);
        chk("unmapped", {30'h0, rr_l}, 32'h2);
        axw(32'h4, 8'h08);
        axr(32'h4);
        chk("dir", rd_l, 32'h8);
        axw(32'h4, 8'h00);
        axw(32'h0, 8'hff);
        axr(32'h0);
        chk("ctl_rw", rd_l, 32'hef);
        wstrb <= 4'h0;
        axw(32'h0, 8'h00);
        wstrb <= 4'h1;
        axr(32'h0);
        chk("wstrb_off", rd_l, 32'hef);
        chk("skips", {30'h0, rxs, txs}, 32'h3);
        axw(32'h0, 8'h01);
        chk("skip_tx", {30'h0, rxs, txs}, 32'h1);
        repeat (6) send();
        axw(32'h0, 8'h84);
        typ = 1'b1;
        gon = 1'b1;
        repeat (20) send();
        rst();
        axw(32'h0, 8'h04);
        repeat (20) send();
        axw(32'h0, 8'h44);
        pend = 1'b1;
        repeat (10) send();
        axw(32'h0, 8'h24);
        inv = 1'b1;
        repeat (6) send();
        axw(32'h0, 8'h00);
        axw(32'h0, 8'h40);
        axw(32'h0, 8'h44);
        inv = 1'b0;
        repeat (6) send();
        axw(32'h4, 8'h08);
        sw <= 1'b1;
        axw(32'h0, 8'h04);
        repeat (6) send();
        axw(32'h0, 8'h64);
        pend = 1'b1;
        inv = 1'b1;
        repeat (8) send();
        rst();
        loop <= 1'b1;
        axw(32'hc, 8'h01);
        axw(32'h0, 8'h0c);
        repeat (80) send();
        axr(32'h0);
        chk("lock", {31'h0, rd_l[4]}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        axw(32'h8, 8'h01);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        axw(32'h0, 8'h04);
        axr(32'h0);
        chk("unlock", {31'h0, rd_l[4]}, 32'h0);
        axw(32'h4, 8'h08);
        sw <= 1'b1;
        axw(32'h0, 8'h0c);
        repeat (80) send();
        axr(32'h0);
        chk("lock_sw", {31'h0, rd_l[4]}, 32'h1);
        end_sim();
    end
endmodule : ebc_bert_ctrl_tb
`default_nettype wire
